// ### logic/dual_event_timer.sv
// Strobed register access was decided locally.
`timescale 1ns/1ps
module dual_event_timer
	import evt_timer_pkg::*;
(
	input  wire logic        i_clk,
	input  wire logic        i_rst,
	input  wire logic [15:0] i_addr,
	input  wire logic [7:0]  i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic      [7:0]  o_rdata,
	input  wire logic [7:0]  i_port0_latch,
	input  wire logic [7:0]  i_port0_pin,
	output logic      [7:0]  o_port0_out,
	output logic      [7:0]  o_port0_oe_n,
	output logic      [1:0]  o_match_irq,
	output logic      [1:0]  o_timer_output
);

	localparam int unsigned NCH = 2;

	logic [7:0]            port0_dir_r;
	logic [7:0]            port0_dir_nxt;
	logic [NCH-1:0][7:0]   mode_r;
	logic [NCH-1:0][7:0]   mode_nxt;
	logic [NCH-1:0][2:0]   clksel_r;
	logic [NCH-1:0][2:0]   clksel_nxt;
	logic [NCH-1:0][7:0]   cmp_r;
	logic [NCH-1:0][7:0]   cmp_nxt;
	logic [NCH-1:0][7:0]   count_r;
	logic [NCH-1:0][7:0]   count_nxt;
	logic [NCH-1:0]        outff_r;
	logic [NCH-1:0]        outff_nxt;
	logic [NCH-1:0]        irq_r;
	logic [NCH-1:0]        irq_nxt;
	logic [7:0]            rdata_r;
	logic [7:0]            rdata_nxt;
	logic [PRESCALE_W-1:0] tick;
	logic [NCH-1:0]        evt_pulse;
	logic [NCH-1:0]        cnt_tick;
	logic [NCH-1:0]        match;
	logic [NCH-1:0][15:0]  mode_ofs;
	logic [NCH-1:0][15:0]  clksel_ofs;
	logic [NCH-1:0][15:0]  cmp_ofs;
	logic [NCH-1:0][15:0]  count_ofs;

	assign mode_ofs   = {OFS_CH1_MODE, OFS_CH0_MODE};
	assign clksel_ofs = {OFS_CH1_CLKSEL, OFS_CH0_CLKSEL};
	assign cmp_ofs    = {OFS_CH1_CMP, OFS_CH0_CMP};
	assign count_ofs  = {OFS_CH1_COUNT, OFS_CH0_COUNT};

	prescaler #(
		.WIDTH (PRESCALE_W)
	) u_prescaler (
		.i_clk  (i_clk),
		.i_rst  (i_rst),
		.o_tick (tick)
	);

	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_chan
			// event pin shares the port-0 pin 6 or 7
			edge_sync u_edge (
				.i_clk    (i_clk),
				.i_rst    (i_rst),
				.i_pin    (i_port0_pin[6+g]),
				.i_rising (clksel_r[g] == CS_EXT_RISE),
				.o_pulse  (evt_pulse[g])
			);

			always_comb
			begin
				case (clksel_r[g])
					CS_EXT_FALL,
					CS_EXT_RISE: cnt_tick[g] = evt_pulse[g];
					CS_DIV1:     cnt_tick[g] = 1'b1;
					CS_DIV2:     cnt_tick[g] = tick[TAP_DIV2-1];
					CS_DIV8:     cnt_tick[g] = tick[TAP_DIV8-1];
					CS_DIV32:    cnt_tick[g] = tick[TAP_DIV32-1];
					CS_DIV128:   cnt_tick[g] = tick[TAP_DIV128-1];
					CS_DIVTOP:   cnt_tick[g] = (g == 0) ? tick[TAP_CH0_TOP-1] : tick[TAP_CH1_TOP-1];
					default:     cnt_tick[g] = 1'b0;
				endcase
			end

			assign match[g] = mode_r[g][BIT_COUNT_EN] & cnt_tick[g] & (count_r[g] == cmp_r[g]);

			// pin drives from the output flip-flop when enabled, else the port latch
			assign o_port0_out[6+g] = mode_r[g][BIT_OUT_EN] ? outff_r[g] : i_port0_latch[6+g];
		end
	endgenerate

	assign o_port0_out[5:0] = i_port0_latch[5:0];
	assign o_port0_oe_n     = port0_dir_r;

	always_comb
	begin
		port0_dir_nxt = port0_dir_r;
		mode_nxt      = mode_r;
		clksel_nxt    = clksel_r;
		cmp_nxt       = cmp_r;
		count_nxt     = count_r;
		outff_nxt     = outff_r;
		irq_nxt       = '0;
		rdata_nxt     = '0;

		if (i_wr && i_addr == OFS_PORT0_DIR)
			port0_dir_nxt = i_wdata;

		for (int c = 0; c < NCH; c++)
		begin
			if (!mode_r[c][BIT_COUNT_EN])
				count_nxt[c] = '0;
			else if (match[c])
			begin
				count_nxt[c] = '0;
				irq_nxt[c]   = 1'b1;
				// toggle only in clear-and-start mode with invert set
				if (mode_r[c][BIT_INVERT] && !mode_r[c][BIT_MODE_SEL])
					outff_nxt[c] = ~outff_r[c];
			end
			else if (cnt_tick[c])
				count_nxt[c] = count_r[c] + 8'h01;

			if (i_wr && i_addr == mode_ofs[c])
			begin
				// cascade bit kept on both channels (both masks hold bit 4); bit 5 not stored
				mode_nxt[c] = i_wdata & ((c == 0) ? MODE_STORE_MASK : CH1_STORE_MASK);
				if (c == 1)
					mode_nxt[c][BIT_CASCADE] = i_wdata[BIT_CASCADE];
				// 1/1 is prohibited; it is treated as no change
				if (i_wdata[BIT_SET_REQ] && !i_wdata[BIT_CLR_REQ])
					outff_nxt[c] = 1'b1;
				else if (!i_wdata[BIT_SET_REQ] && i_wdata[BIT_CLR_REQ])
					outff_nxt[c] = 1'b0;
			end
			if (i_wr && i_addr == clksel_ofs[c])
				clksel_nxt[c] = i_wdata[2:0];
			if (i_wr && i_addr == cmp_ofs[c])
				cmp_nxt[c] = i_wdata;

			if (i_rd && i_addr == mode_ofs[c])
				rdata_nxt = mode_r[c];
			if (i_rd && i_addr == clksel_ofs[c])
				rdata_nxt = {5'h00, clksel_r[c]};
			if (i_rd && i_addr == cmp_ofs[c])
				rdata_nxt = cmp_r[c];
			if (i_rd && i_addr == count_ofs[c])
				rdata_nxt = count_r[c];
		end

		if (i_rd && i_addr == OFS_PORT0_DIR)
			rdata_nxt = port0_dir_r;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			port0_dir_r <= RST_PORT0_DIR;
			mode_r      <= {NCH{RST_MODE}};
			clksel_r    <= {NCH{RST_CLKSEL[2:0]}};
			cmp_r       <= {NCH{RST_CMP}};
			count_r     <= '0;
			outff_r     <= '0;
			irq_r       <= '0;
			rdata_r     <= '0;
		end
		else
		begin
			port0_dir_r <= port0_dir_nxt;
			mode_r      <= mode_nxt;
			clksel_r    <= clksel_nxt;
			cmp_r       <= cmp_nxt;
			count_r     <= count_nxt;
			outff_r     <= outff_nxt;
			irq_r       <= irq_nxt;
			rdata_r     <= rdata_nxt;
		end
	end

	assign o_rdata        = rdata_r;
	assign o_match_irq    = irq_r;
	assign o_timer_output = outff_r;

	sequence s_ch0_match;
		mode_r[0][BIT_COUNT_EN] && cnt_tick[0] && count_r[0] == cmp_r[0];
	endsequence

	a_stop_clears: assert property (@(posedge i_clk) disable iff (i_rst)
		!mode_r[0][BIT_COUNT_EN] |=> count_r[0] == 8'h00)
		else $error("stopped counter not zero");

	a_match_irq: assert property (@(posedge i_clk) disable iff (i_rst)
		s_ch0_match |=> o_match_irq[0] && count_r[0] == 8'h00)
		else $error("match did not clear counter or raise irq");

	a_no_spur_irq: assert property (@(posedge i_clk) disable iff (i_rst)
		!$past(match[1]) |-> !o_match_irq[1])
		else $error("irq without match");

	a_req_reads_zero: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rd && i_addr == OFS_CH1_MODE) |=> o_rdata[3:2] == 2'b00)
		else $error("request bits read non-zero");

	a_dir_reset: assert property (@(posedge i_clk) disable iff (i_rst)
		$rose(!i_rst) |-> port0_dir_r == 8'hFF)
		else $error("direction not all inputs");

	a_dir_oe: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == OFS_PORT0_DIR) |=> o_port0_oe_n == $past(i_wdata))
		else $error("pin enable does not follow direction");

	a_toggle: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ch0_match and (mode_r[0][BIT_INVERT] && !mode_r[0][BIT_MODE_SEL] && !i_wr))
		|=> o_timer_output[0] != $past(o_timer_output[0]))
		else $error("output did not toggle on match");

	a_force_high: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == OFS_CH1_MODE && i_wdata[3:2] == 2'b10) |=> o_timer_output[1])
		else $error("set request did not force high");

	a_div1_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(mode_r[1][BIT_COUNT_EN] && clksel_r[1] == CS_DIV1 && !match[1] && !i_wr)
		|=> count_r[1] == $past(count_r[1]) + 8'h01)
		else $error("div1 count did not step");

	// channel 1 guards mirror channel 0 so both generate copies are watched
	sequence s_ch1_match;
		mode_r[1][BIT_COUNT_EN] && cnt_tick[1] && count_r[1] == cmp_r[1];
	endsequence

	a_ch1_match: assert property (@(posedge i_clk) disable iff (i_rst)
		s_ch1_match |=> o_match_irq[1] && count_r[1] == 8'h00)
		else $error("ch1 match did not clear counter or raise irq");

	a_ch1_stop: assert property (@(posedge i_clk) disable iff (i_rst)
		!mode_r[1][BIT_COUNT_EN] |=> count_r[1] == 8'h00)
		else $error("ch1 stopped counter not zero");

	a_ch1_toggle: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ch1_match and (mode_r[1][BIT_INVERT] && !mode_r[1][BIT_MODE_SEL] && !i_wr))
		|=> o_timer_output[1] != $past(o_timer_output[1]))
		else $error("ch1 output did not toggle on match");

	a_no_toggle: assert property (@(posedge i_clk) disable iff (i_rst)
		(s_ch1_match and (!mode_r[1][BIT_INVERT] && !i_wr)) |=> $stable(o_timer_output[1]))
		else $error("output toggled with invert off");

	a_force_low: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_wr && i_addr == OFS_CH0_MODE && i_wdata[3:2] == 2'b01) |=> !o_timer_output[0])
		else $error("clear request did not force low");

	a_pin_mux: assert property (@(posedge i_clk) disable iff (i_rst)
		mode_r[0][BIT_OUT_EN] |-> o_port0_out[6] == o_timer_output[0])
		else $error("enabled pin does not show output flip-flop");

	a_port_mode: assert property (@(posedge i_clk) disable iff (i_rst)
		!mode_r[1][BIT_OUT_EN] |-> o_port0_out[7] == i_port0_latch[7])
		else $error("disabled pin does not show port latch");

	a_evt_step: assert property (@(posedge i_clk) disable iff (i_rst)
		(mode_r[0][BIT_COUNT_EN] && clksel_r[0] == CS_EXT_FALL && evt_pulse[0] && !match[0])
		|=> count_r[0] == $past(count_r[0]) + 8'h01)
		else $error("event edge did not step counter");

	a_hold_no_tick: assert property (@(posedge i_clk) disable iff (i_rst)
		(mode_r[1][BIT_COUNT_EN] && !cnt_tick[1]) |=> count_r[1] == $past(count_r[1]))
		else $error("counter moved without a count tick");

	a_clksel_rd: assert property (@(posedge i_clk) disable iff (i_rst)
		(i_rd && i_addr == OFS_CH0_CLKSEL) |=> o_rdata[7:3] == 5'h00)
		else $error("clock select upper bits read non-zero");

	a_rdata_idle: assert property (@(posedge i_clk) disable iff (i_rst)
		!i_rd |=> o_rdata == 8'h00)
		else $error("read data present without a read");

endmodule

// ### logic/edge_sync.sv
`timescale 1ns/1ps
module edge_sync
(
	input  wire logic i_clk,
	input  wire logic i_rst,
	input  wire logic i_pin,
	input  wire logic i_rising,
	output logic      o_pulse
);

	logic meta_r;
	logic sync_r;
	logic last_r;
	logic pulse_r;
	logic pulse_nxt;

	always_comb
	begin
		if (i_rising)
			pulse_nxt = sync_r & ~last_r;
		else
			pulse_nxt = ~sync_r & last_r;
	end

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			// pin idles high; a low reset would fake an edge on release
			meta_r  <= 1'b1;
			sync_r  <= 1'b1;
			last_r  <= 1'b1;
			pulse_r <= 1'b0;
		end
		else
		begin
			meta_r  <= i_pin;
			sync_r  <= meta_r;
			last_r  <= sync_r;
			pulse_r <= pulse_nxt;
		end
	end

	assign o_pulse = pulse_r;

	a_pulse_single: assert property (@(posedge i_clk) disable iff (i_rst)
		o_pulse |=> !o_pulse)
		else $error("edge pulse longer than one cycle");

endmodule

// ### logic/evt_timer_pkg.sv
package evt_timer_pkg;

	localparam int unsigned CLK_HZ = 20000000;

	// register offsets (byte addresses of the 16-bit map)
	localparam logic [15:0] OFS_PORT0_DIR  = 16'hFF20;
	localparam logic [15:0] OFS_CH0_COUNT  = 16'hFF50;
	localparam logic [15:0] OFS_CH1_COUNT  = 16'hFF54;
	localparam logic [15:0] OFS_CH0_CMP    = 16'hFF58;
	localparam logic [15:0] OFS_CH1_CMP    = 16'hFF5C;
	localparam logic [15:0] OFS_CH0_MODE   = 16'hFF70;
	localparam logic [15:0] OFS_CH0_CLKSEL = 16'hFF6C;
	localparam logic [15:0] OFS_CH1_MODE   = 16'hFF74;
	localparam logic [15:0] OFS_CH1_CLKSEL = 16'hFF75;

	// mode control field positions
	localparam int unsigned BIT_OUT_EN     = 0;
	localparam int unsigned BIT_INVERT     = 1;
	localparam int unsigned BIT_CLR_REQ    = 2;
	localparam int unsigned BIT_SET_REQ    = 3;
	localparam int unsigned BIT_CASCADE    = 4;
	localparam int unsigned BIT_MODE_SEL   = 6;
	localparam int unsigned BIT_COUNT_EN   = 7;

	// stored bits of the mode control registers; request bits never stored
	localparam logic [7:0] MODE_STORE_MASK = 8'hD3;
	localparam logic [7:0] CH1_STORE_MASK  = 8'hD3;

	localparam logic [7:0] RST_PORT0_DIR   = 8'hFF;
	localparam logic [7:0] RST_MODE        = 8'h00;
	localparam logic [7:0] RST_CLKSEL      = 8'h00;
	localparam logic [7:0] RST_CMP         = 8'h00;

	// clock select codes
	localparam logic [2:0] CS_EXT_FALL = 3'h0;
	localparam logic [2:0] CS_EXT_RISE = 3'h1;
	localparam logic [2:0] CS_DIV1     = 3'h2;
	localparam logic [2:0] CS_DIV2     = 3'h3;
	localparam logic [2:0] CS_DIV8     = 3'h4;
	localparam logic [2:0] CS_DIV32    = 3'h5;
	localparam logic [2:0] CS_DIV128   = 3'h6;
	localparam logic [2:0] CS_DIVTOP   = 3'h7;

	// divider tap positions (log2 of the division ratio)
	localparam int unsigned TAP_DIV2    = 1;
	localparam int unsigned TAP_DIV8    = 3;
	localparam int unsigned TAP_DIV32   = 5;
	localparam int unsigned TAP_DIV128  = 7;
	localparam int unsigned TAP_CH0_TOP = 9;
	localparam int unsigned TAP_CH1_TOP = 12;
	localparam int unsigned PRESCALE_W  = 12;

endpackage

// ### logic/prescaler.sv
`timescale 1ns/1ps
module prescaler
	import evt_timer_pkg::*;
#(
	parameter int unsigned WIDTH = PRESCALE_W
)
(
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	output logic      [WIDTH-1:0] o_tick
);

	logic [WIDTH-1:0] div_r;
	logic [WIDTH-1:0] div_nxt;
	logic [WIDTH-1:0] tick_r;
	logic [WIDTH-1:0] tick_nxt;

	initial
	begin
		if (WIDTH < 2 || WIDTH > 16)
			$error("prescaler width out of range");
	end

	always_comb
	begin
		div_nxt = div_r + {{(WIDTH-1){1'b0}}, 1'b1};
	end

	// free running; tap k pulses once per 2^k cycles
	genvar k;
	generate
		for (k = 1; k <= WIDTH; k++)
		begin : g_tap
			assign tick_nxt[k-1] = (div_r[k-1:0] == {k{1'b1}});
		end
	endgenerate

	always_ff @(posedge i_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			div_r  <= '0;
			tick_r <= '0;
		end
		else
		begin
			div_r  <= div_nxt;
			tick_r <= tick_nxt;
		end
	end

	assign o_tick = tick_r;

	a_tick_period: assert property (@(posedge i_clk) disable iff (i_rst)
		o_tick[0] |=> !o_tick[0] ##1 o_tick[0])
		else $error("div2 tick period wrong");

endmodule

// ### test/dual_event_timer_test.sv
`timescale 1ns/1ps
module dual_event_timer_test;
	import evt_timer_pkg::*;
	logic        clk   = 1'b0;
	logic        rst   = 1'b1;
	logic [15:0] addr  = 16'h0000;
	logic [7:0]  wdata = 8'h00;
	logic        wr    = 1'b0;
	logic        rd    = 1'b0;
	logic [7:0]  latch = 8'h3C;
	logic [1:0]  tog   = 2'h0;
	logic [7:0]  rdata;
	logic [7:0]  pin;
	logic [7:0]  pout;
	logic [7:0]  oe_n;
	logic [1:0]  irq;
	logic [1:0]  tout;
	int          n_mismatch;
	int          comparisons;
	int          cycles;
	int          irq_n[2];
	logic [15:0] mode_a[2] = '{OFS_CH0_MODE, OFS_CH1_MODE};
	logic [15:0] cs_a[2]   = '{OFS_CH0_CLKSEL, OFS_CH1_CLKSEL};
	logic [15:0] cmp_a[2]  = '{OFS_CH0_CMP, OFS_CH1_CMP};
	logic [15:0] cnt_a[2]  = '{OFS_CH0_COUNT, OFS_CH1_COUNT};

	always #25 clk = ~clk;

	dual_event_timer DUT
	(
		.i_clk          (clk),
		.i_rst          (rst),
		.i_addr         (addr),
		.i_wdata        (wdata),
		.i_wr           (wr),
		.i_rd           (rd),
		.o_rdata        (rdata),
		.i_port0_latch  (latch),
		.i_port0_pin    (pin),
		.o_port0_out    (pout),
		.o_port0_oe_n   (oe_n),
		.o_match_irq    (irq),
		.o_timer_output (tout)
	);

	evt_source src
	(
		.i_clk    (clk),
		.i_toggle (tog),
		.i_out    (pout),
		.i_oe_n   (oe_n),
		.o_pin    (pin)
	);

	task complete_run;
		if (n_mismatch == 0 && comparisons > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cycles++;
		irq_n[0] += irq[0];
		irq_n[1] += irq[1];
		if (cycles == 40000)
		begin
			n_mismatch++;
			complete_run;
		end
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		comparisons++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("Error %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task settle;
		@(posedge clk);
		#1;
	endtask

	task wr8(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task rd8(input logic [15:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		check(rdata, e);
	endtask

	// stop first so mode bits never change under a running count; bit 5 kept 0
	task setup(input int ch, input logic [2:0] cs, input logic [7:0] cmp, input logic [7:0] m);
		wr8(mode_a[ch], 8'h00);
		wr8(cs_a[ch], {5'h00, cs});
		wr8(cmp_a[ch], cmp);
		wr8(mode_a[ch], m);
	endtask

	task wait_irq(input int ch, input int lim, output int n);
		n = 0;
		do
		begin
			@(posedge clk);
			#1;
			n++;
		end while (irq[ch] !== 1'b1 && n < lim);
	endtask

	// first interval may be short by one tick, so only the second is judged
	task t_interval(input int ch, input logic [2:0] cs, input logic [7:0] cmp, input int exp);
		int n;
		setup(ch, cs, cmp, 8'h80);
		wait_irq(ch, 2 * exp + 20, n);
		wait_irq(ch, exp + 2, n);
		check(16'(n), 16'(exp));
		wr8(mode_a[ch], 8'h00);
	endtask

	task t_stop;
		int k;
		setup(0, CS_DIV1, 8'hFF, 8'h80);
		repeat (10) @(posedge clk);
		wr8(mode_a[0], 8'h00);
		k = irq_n[0];
		rd8(cnt_a[0], 8'h00);
		repeat (300) @(posedge clk);
		check(16'(irq_n[0]), 16'(k));
	endtask

	task t_force(input int ch);
		wr8(mode_a[ch], 8'h09);
		settle;
		check(tout[ch], 1'b1);
		check(pout[6+ch], 1'b1);
		rd8(mode_a[ch], 8'h01);
		wr8(mode_a[ch], 8'h00);
		settle;
		check(pout[6+ch], 1'b0);
		check(tout[ch], 1'b1);
		wr8(mode_a[ch], 8'h05);
		settle;
		check(tout[ch], 1'b0);
		rd8(mode_a[ch], 8'h01);
	endtask

	task t_square(input int ch, input logic [7:0] m, input logic flip);
		int n;
		logic v;
		setup(ch, CS_DIV1, 8'h04, m);
		wait_irq(ch, 30, n);
		v = tout[ch];
		wait_irq(ch, 10, n);
		check(16'(n), 16'd5);
		check(tout[ch], v ^ flip);
		check(pout[6+ch], tout[ch]);
	endtask

	task edge_pair(input int ch);
		repeat (2)
		begin
			@(posedge clk);
			tog[ch] <= 1'b1;
			@(posedge clk);
			tog <= 2'h0;
			repeat (6) @(posedge clk);
		end
	endtask

	// level starts high: each pair is one fall then one rise
	task t_event(input int ch, input logic [2:0] cs);
		int k;
		setup(ch, cs, 8'h02, 8'h80);
		k = irq_n[ch];
		edge_pair(ch);
		edge_pair(ch);
		rd8(cnt_a[ch], 8'h02);
		check(16'(irq_n[ch]), 16'(k));
		edge_pair(ch);
		check(16'(irq_n[ch]), 16'(k + 1));
		rd8(cnt_a[ch], 8'h00);
		wr8(mode_a[ch], 8'h00);
	endtask

	initial
	begin
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		check(oe_n, 8'hFF);
		check(pout, latch);
		rd8(OFS_PORT0_DIR, 8'hFF);
		rd8(16'h0000, 8'h00);
		rd8(OFS_CH1_MODE, 8'h00);
		wr8(OFS_PORT0_DIR, 8'h5A);
		settle;
		check(oe_n, 8'h5A);
		rd8(OFS_PORT0_DIR, 8'h5A);
		wr8(OFS_PORT0_DIR, 8'hFF);
		t_event(0, CS_EXT_FALL);
		t_event(1, CS_EXT_RISE);
		t_interval(0, CS_DIV1, 8'h02, 3);
		t_interval(0, CS_DIV2, 8'h03, 8);
		t_interval(0, CS_DIV8, 8'h01, 16);
		t_interval(0, CS_DIV32, 8'h00, 32);
		t_interval(0, CS_DIV128, 8'h00, 128);
		t_interval(0, CS_DIVTOP, 8'h00, 512);
		t_interval(1, CS_DIVTOP, 8'h00, 4096);
		t_interval(1, CS_DIV1, 8'hFF, 256);
		t_stop;
		wr8(OFS_PORT0_DIR, 8'h3F);
		t_force(0);
		t_force(1);
		t_square(0, 8'h83, 1'b1);
		t_square(1, 8'h83, 1'b1);
		t_square(1, 8'h81, 1'b0);
		complete_run;
	end
endmodule

// ### test/evt_source.sv
`timescale 1ns/1ps
module evt_source
(
	input  wire logic       i_clk,
	input  wire logic [1:0] i_toggle,
	input  wire logic [7:0] i_out,
	input  wire logic [7:0] i_oe_n,
	output logic      [7:0] o_pin
);
	logic [1:0] lvl_r = 2'h3;
	always @(posedge i_clk)
		lvl_r <= lvl_r ^ i_toggle;
	// pins 0..5 rest on pull-ups when not driven
	always_comb
		for (int i = 0; i < 8; i++)
			o_pin[i] = !i_oe_n[i] ? i_out[i] : (i >= 6 ? lvl_r[i-6] : 1'b1);
endmodule
